/* sccb_pkg.sv */
// Package: constants and types for the servo command control-bit decoder
package sccb_pkg;

  // Cyclic command code field (bits 6 to 4 of byte 1)
  localparam int unsigned CYC_W       = 3;
  localparam logic [2:0]  CYC_PROFILE = 3'h1;

  // Non-cyclic command code field (bits 3 to 0 of byte 1)
  localparam int unsigned NCY_W       = 4;
  localparam logic [3:0]  NCY_HOMING  = 4'h4;

  // Parameter widths and enabling values
  localparam int unsigned PRM_W       = 4;
  localparam logic [3:0]  SFB_MODE_VFULL   = 4'h0;
  localparam logic [3:0]  SFB_MODE_DISP    = 4'h1;
  localparam logic [3:0]  TLIM_SEL_A       = 4'h3;
  localparam logic [3:0]  TLIM_SEL_B       = 4'h4;
  localparam logic [3:0]  SLIM_SEL_ON      = 4'h1;

  // Control-bit field positions within the 16-bit field
  localparam int unsigned CB_W        = 16;
  localparam int unsigned B_SERVO_ON  = 15;
  localparam int unsigned B_FB_CTRL   = 14;
  localparam int unsigned B_GAIN      = 13;
  localparam int unsigned B_TLIM      = 12;
  localparam int unsigned B_HOME_ARM  = 11;
  localparam int unsigned B_EHALT     = 10;
  localparam int unsigned B_CHALT     = 9;
  localparam int unsigned B_PAUSE     = 8;
  localparam int unsigned B_SLIM      = 7;
  localparam int unsigned B_OUT_TWO   = 1;
  localparam int unsigned B_OUT_ONE   = 0;

  localparam logic [15:0] CB_RESET    = 16'h0000;

  // Profile stop request encoding
  typedef enum logic [1:0] {
    SCCB_STOP_NONE,
    SCCB_STOP_EMERG,
    SCCB_STOP_DECEL,
    SCCB_STOP_PAUSE
  } sccb_stop_e;

endpackage : sccb_pkg

/* sccb_ctrl.sv */
// Decoder for the control-bit field of each cyclic command frame
//
// Behaviour
// - Servo-enable bit: 0 off, 1 on
// - Mapped external enable ANDs with command bit
// - Dropping servo-enable during retract raises alarms
// - Feedback bit role chosen by sensor mode
// - Virtual role: 0 full-closed, 1 virtual
// - Sensor role: 0 disable, 1 enable displacement
// - Gain bit: 0 first, 1 second set
// - Gain bit needs tuning off, gain2, net switch
// - Torque-limit bit honoured for selection 3 or 4
// - Homing arm enables home trigger detection
// - Homing arm ignored unless homing command
// - Emergency halt stops profile immediately
// - Controlled halt decelerates, then ends profile
// - Pause decelerates and holds without ending
// - Speed-limit bit honoured for selection 1
// - Network outputs drive only when assigned
// - Network outputs never affect servo control
// - Profile mode is cyclic code 1
`timescale 1ns/1ns
`default_nettype none

module sccb_ctrl
  import sccb_pkg::*;
(
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_frame_valid,
  input  wire logic [CB_W-1:0]  i_ctrl_bits,
  input  wire logic [CYC_W-1:0] i_cyclic_code,
  input  wire logic [NCY_W-1:0] i_noncyclic_code,
  input  wire logic             i_ctrl_cycle,
  input  wire logic             i_ext_enable_assigned,
  input  wire logic             i_external_servo_enable_input,
  input  wire logic             i_retract_active_flag,
  input  wire logic [PRM_W-1:0] i_sensor_feedback_mode_param,
  input  wire logic             i_rt_autotune_on,
  input  wire logic             i_second_gain_en,
  input  wire logic             i_net_gain_switch_en,
  input  wire logic [PRM_W-1:0] i_torque_limit_selection_param,
  input  wire logic [PRM_W-1:0] i_speed_limit_selection_param,
  input  wire logic             i_home_trigger,
  input  wire logic             i_out_one_assigned,
  input  wire logic             i_out_two_assigned,
  output logic                  o_servo_on,
  output logic                  o_virtual_full_closed,
  output logic                  o_displacement_control_enable,
  output logic                  o_gain_select_bit,
  output logic                  o_torque_limit_select_bit,
  output logic                  o_speed_limit_select_bit,
  output logic                  o_home_armed,
  output logic                  o_home_detected,
  output logic                  o_profile_position_mode,
  output logic                  o_profile_stop_gen,
  output logic                  o_profile_end,
  output logic                  o_profile_decel,
  output logic                  o_profile_hold,
  output logic                  o_retract_error_alarm_a,
  output logic                  o_retract_error_alarm_b,
  output logic                  o_network_output_one,
  output logic                  o_network_output_two
);

  // ----------------------------------------------------------------
  // Input synchronisers for pin-level signals
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s1_d;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s2_d;

  always_comb begin
    pin_s1_d = {i_home_trigger, i_retract_active_flag, i_external_servo_enable_input};
    pin_s2_d = pin_s1_q;
    if (!i_rst_n) begin
      pin_s1_d = 3'h0;
      pin_s2_d = 3'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    pin_s1_q <= pin_s1_d;
    pin_s2_q <= pin_s2_d;
  end

  logic ext_en_s;
  logic retract_s;
  logic home_trig_s;
  assign ext_en_s    = pin_s2_q[0];
  assign retract_s   = pin_s2_q[1];
  assign home_trig_s = pin_s2_q[2];

  // ----------------------------------------------------------------
  // Frame latch and apply stage
  // ----------------------------------------------------------------
  logic [CB_W-1:0]  rx_bits_q;
  logic [CB_W-1:0]  rx_bits_d;
  logic [CYC_W-1:0] rx_cyc_q;
  logic [CYC_W-1:0] rx_cyc_d;
  logic [NCY_W-1:0] rx_ncy_q;
  logic [NCY_W-1:0] rx_ncy_d;
  logic [CB_W-1:0]  cb_q;
  logic [CB_W-1:0]  cb_d;
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] cyc_d;
  logic [NCY_W-1:0] ncy_q;
  logic [NCY_W-1:0] ncy_d;

  always_comb begin
    rx_bits_d = rx_bits_q;
    rx_cyc_d  = rx_cyc_q;
    rx_ncy_d  = rx_ncy_q;
    cb_d      = cb_q;
    cyc_d     = cyc_q;
    ncy_d     = ncy_q;
    if (i_frame_valid) begin
      rx_bits_d = i_ctrl_bits;
      rx_cyc_d  = i_cyclic_code;
      rx_ncy_d  = i_noncyclic_code;
    end
    if (i_ctrl_cycle) begin
      cb_d  = rx_bits_q;
      cyc_d = rx_cyc_q;
      ncy_d = rx_ncy_q;
    end
    if (!i_rst_n) begin
      rx_bits_d = CB_RESET;
      rx_cyc_d  = '0;
      rx_ncy_d  = '0;
      cb_d      = CB_RESET;
      cyc_d     = '0;
      ncy_d     = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    rx_bits_q <= rx_bits_d;
    rx_cyc_q  <= rx_cyc_d;
    rx_ncy_q  <= rx_ncy_d;
    cb_q      <= cb_d;
    cyc_q     <= cyc_d;
    ncy_q     <= ncy_d;
  end

  // ----------------------------------------------------------------
  // Decode of applied bits
  // ----------------------------------------------------------------
  logic       servo_req;
  logic       profile_mode;
  logic       fb_bit;
  sccb_stop_e stop_req;

  assign servo_req = cb_q[B_SERVO_ON]
                   & (ext_en_s | ~i_ext_enable_assigned);
  assign profile_mode = (cyc_q == CYC_PROFILE);
  assign fb_bit    = cb_q[B_FB_CTRL];

  // Emergency halt outranks controlled halt, which outranks pause
  always_comb begin
    stop_req = SCCB_STOP_NONE;
    if (profile_mode) begin
      if (cb_q[B_EHALT]) begin
        stop_req = SCCB_STOP_EMERG;
      end else if (cb_q[B_CHALT]) begin
        stop_req = SCCB_STOP_DECEL;
      end else if (cb_q[B_PAUSE]) begin
        stop_req = SCCB_STOP_PAUSE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [16:0] out_q;
  logic [16:0] out_d;

  always_comb begin
    out_d     = '0;
    out_d[0]  = servo_req;
    out_d[1]  = (i_sensor_feedback_mode_param == SFB_MODE_VFULL) & fb_bit;
    out_d[2]  = (i_sensor_feedback_mode_param == SFB_MODE_DISP) & fb_bit;
    out_d[3]  = cb_q[B_GAIN] & ~i_rt_autotune_on & i_second_gain_en
              & i_net_gain_switch_en;
    out_d[4]  = cb_q[B_TLIM] & ((i_torque_limit_selection_param == TLIM_SEL_A)
              | (i_torque_limit_selection_param == TLIM_SEL_B));
    out_d[5]  = cb_q[B_SLIM]
              & (i_speed_limit_selection_param == SLIM_SEL_ON);
    out_d[6]  = cb_q[B_HOME_ARM] & (ncy_q == NCY_HOMING);
    out_d[7]  = out_d[6] & home_trig_s;
    out_d[8]  = profile_mode;
    out_d[9]  = (stop_req == SCCB_STOP_EMERG);
    out_d[10] = (stop_req == SCCB_STOP_EMERG) | (stop_req == SCCB_STOP_DECEL);
    out_d[11] = (stop_req == SCCB_STOP_DECEL) | (stop_req == SCCB_STOP_PAUSE);
    out_d[12] = (stop_req == SCCB_STOP_PAUSE);
    // Sticky alarms: servo dropped while retracting
    out_d[13] = out_q[13] | (retract_s & ~servo_req);
    out_d[14] = out_q[14] | (retract_s & ~servo_req);
    out_d[15] = cb_q[B_OUT_ONE] & i_out_one_assigned;
    out_d[16] = cb_q[B_OUT_TWO] & i_out_two_assigned;
    if (!i_rst_n) begin
      out_d = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    out_q <= out_d;
  end

  assign o_servo_on                    = out_q[0];
  assign o_virtual_full_closed         = out_q[1];
  assign o_displacement_control_enable = out_q[2];
  assign o_gain_select_bit             = out_q[3];
  assign o_torque_limit_select_bit     = out_q[4];
  assign o_speed_limit_select_bit      = out_q[5];
  assign o_home_armed                  = out_q[6];
  assign o_home_detected               = out_q[7];
  assign o_profile_position_mode       = out_q[8];
  assign o_profile_stop_gen            = out_q[9];
  assign o_profile_end                 = out_q[10];
  assign o_profile_decel               = out_q[11];
  assign o_profile_hold                = out_q[12];
  assign o_retract_error_alarm_a       = out_q[13];
  assign o_retract_error_alarm_b       = out_q[14];
  assign o_network_output_one          = out_q[15];
  assign o_network_output_two          = out_q[16];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_servo_and;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ext_enable_assigned && !ext_en_s) |=> !o_servo_on;
  endproperty
  a_servo_and: assert property (p_servo_and) else $error("servo on without external enable");

  property p_servo_on;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (cb_q[B_SERVO_ON] && !i_ext_enable_assigned) |=> o_servo_on;
  endproperty
  a_servo_on: assert property (p_servo_on) else $error("servo request not honoured");

  property p_retract;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (retract_s && !servo_req) |=> (o_retract_error_alarm_a && o_retract_error_alarm_b);
  endproperty
  a_retract: assert property (p_retract) else $error("retract alarm missing");

  property p_fb_roles;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_sensor_feedback_mode_param != SFB_MODE_VFULL) |=> !o_virtual_full_closed;
  endproperty
  a_fb_roles: assert property (p_fb_roles) else $error("virtual role outside its mode");

  property p_gain;
    @(posedge i_mclk) disable iff (!i_rst_n)
      i_rt_autotune_on |=> !o_gain_select_bit;
  endproperty
  a_gain: assert property (p_gain) else $error("gain switched under auto tuning");

  property p_tlim;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_torque_limit_selection_param == TLIM_SEL_A && cb_q[B_TLIM]) |=> o_torque_limit_select_bit;
  endproperty
  a_tlim: assert property (p_tlim) else $error("torque limit bit lost");

  property p_slim;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_speed_limit_selection_param != SLIM_SEL_ON) |=> !o_speed_limit_select_bit;
  endproperty
  a_slim: assert property (p_slim) else $error("speed limit bit not gated");

  property p_home;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (ncy_q != NCY_HOMING) |=> !o_home_armed;
  endproperty
  a_home: assert property (p_home) else $error("homing arm outside homing command");

  property p_halt_profile;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (cyc_q != CYC_PROFILE) |=> !(o_profile_end || o_profile_decel);
  endproperty
  a_halt_profile: assert property (p_halt_profile) else $error("profile stop outside profile mode");

  property p_latch;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_frame_valid ##1 i_ctrl_cycle && !i_frame_valid) |=> (cb_q == $past(i_ctrl_bits, 2));
  endproperty
  a_latch: assert property (p_latch) else $error("frame bits not applied");

  c_servo:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_servo_on));
  c_emerg:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_profile_stop_gen);
  c_pause:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_profile_hold);
  c_homed:  cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_home_detected);

endmodule : sccb_ctrl

`default_nettype wire

/* sccb_host.sv */
// Host controller model issuing cyclic command frames
`timescale 1ns/1ns
`default_nettype none

module sccb_host
  import sccb_pkg::*;
(
  input  wire logic        i_mclk,
  output logic             o_frame_valid,
  output logic             o_ctrl_cycle,
  output logic [CB_W-1:0]  o_ctrl_bits,
  output logic [CYC_W-1:0] o_cyclic_code,
  output logic [NCY_W-1:0] o_noncyclic_code
);
  initial begin
    o_frame_valid = 1'h0;
    o_ctrl_cycle = 1'h0;
    o_ctrl_bits = 16'h0000;
    o_cyclic_code = 3'h0;
    o_noncyclic_code = 4'h0;
  end

  // Optional frame, then optional control cycle; data inverted once released
  task automatic send(input logic [CB_W-1:0] cb, input logic [CYC_W-1:0] cy,
                      input logic [NCY_W-1:0] nc, input logic frm, input logic app);
    @(posedge i_mclk);
    #10;
    o_frame_valid = frm;
    o_ctrl_bits = cb;
    o_cyclic_code = cy;
    o_noncyclic_code = nc;
    @(posedge i_mclk);
    #10;
    o_frame_valid = 1'h0;
    o_ctrl_bits = ~cb;
    o_cyclic_code = ~cy;
    o_noncyclic_code = ~nc;
    o_ctrl_cycle = app;
    @(posedge i_mclk);
    #10;
    o_ctrl_cycle = 1'h0;
  endtask : send
endmodule : sccb_host

`default_nettype wire

/* sccb_tb.sv */
// Self-checking testbench for the control-bit decoder
`timescale 1ns/1ns
`default_nettype none

module testbench
  import sccb_pkg::*;
;
  logic i_mclk, i_rst_n, i_frame_valid, i_ctrl_cycle, i_home_trigger;
  logic [CB_W-1:0]  i_ctrl_bits;
  logic [CYC_W-1:0] i_cyclic_code;
  logic [NCY_W-1:0] i_noncyclic_code;
  logic i_ext_enable_assigned, i_external_servo_enable_input, i_retract_active_flag;
  logic [PRM_W-1:0] i_sensor_feedback_mode_param, i_torque_limit_selection_param;
  logic [PRM_W-1:0] i_speed_limit_selection_param;
  logic i_rt_autotune_on, i_second_gain_en, i_net_gain_switch_en;
  logic i_out_one_assigned, i_out_two_assigned, o_servo_on, o_virtual_full_closed;
  logic o_displacement_control_enable, o_gain_select_bit, o_torque_limit_select_bit;
  logic o_speed_limit_select_bit, o_home_armed, o_home_detected, o_profile_position_mode;
  logic o_profile_stop_gen, o_profile_end, o_profile_decel, o_profile_hold;
  logic o_retract_error_alarm_a, o_retract_error_alarm_b;
  logic o_network_output_one, o_network_output_two;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  sccb_ctrl dut (.i_mclk, .i_rst_n, .i_frame_valid, .i_ctrl_bits, .i_cyclic_code,
    .i_noncyclic_code, .i_ctrl_cycle, .i_ext_enable_assigned, .i_external_servo_enable_input,
    .i_retract_active_flag, .i_sensor_feedback_mode_param, .i_rt_autotune_on,
    .i_second_gain_en, .i_net_gain_switch_en, .i_torque_limit_selection_param,
    .i_speed_limit_selection_param, .i_home_trigger, .i_out_one_assigned,
    .i_out_two_assigned, .o_servo_on, .o_virtual_full_closed, .o_displacement_control_enable,
    .o_gain_select_bit, .o_torque_limit_select_bit, .o_speed_limit_select_bit, .o_home_armed,
    .o_home_detected, .o_profile_position_mode, .o_profile_stop_gen, .o_profile_end,
    .o_profile_decel, .o_profile_hold, .o_retract_error_alarm_a, .o_retract_error_alarm_b,
    .o_network_output_one, .o_network_output_two);

  sccb_host host (.i_mclk, .o_frame_valid(i_frame_valid), .o_ctrl_cycle(i_ctrl_cycle),
    .o_ctrl_bits(i_ctrl_bits), .o_cyclic_code(i_cyclic_code),
    .o_noncyclic_code(i_noncyclic_code));

  initial begin
    i_mclk = 1'h0;
    forever #50 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask : tick

  function automatic logic [15:0] cbit(input int p, input logic v);
    return {15'h0000, v} << p;
  endfunction : cbit

  task automatic frm(input logic [15:0] cb, input logic [2:0] cy, input logic [3:0] nc);
    host.send(cb, cy, nc, 1'h1, 1'h1);
    tick(3);
  endtask : frm

  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_main();
    logic e, c, p;
    for (int k = 0; k < 8; k++) begin
      i_ext_enable_assigned = k[2];
      i_external_servo_enable_input = k[1];
      frm(cbit(B_SERVO_ON, k[0]) | 16'h0003, 3'h0, 4'h0);
      chk({4'h0, o_servo_on}, {4'h0, k[0] & (~k[2] | k[1])});
    end
    for (int k = 0; k < 6; k++) begin
      i_sensor_feedback_mode_param = PRM_W'(k / 2);
      frm(cbit(B_FB_CTRL, k[0]), 3'h0, 4'h0);
      chk({o_virtual_full_closed, o_displacement_control_enable}, {k[0] && k < 2, k[0] && k / 2 == 1});
    end
    for (int k = 0; k < 16; k++) begin
      {i_rt_autotune_on, i_second_gain_en, i_net_gain_switch_en} = k[3:1];
      frm(cbit(B_GAIN, k[0]), 3'h0, 4'h0);
      chk({4'h0, o_gain_select_bit}, {4'h0, k[0] & ~k[3] & k[2] & k[1]});
    end
    for (int k = 0; k < 6; k++) begin
      i_torque_limit_selection_param = PRM_W'(k);
      i_speed_limit_selection_param = PRM_W'(k);
      frm(cbit(B_TLIM, 1'h1) | cbit(B_SLIM, 1'h1), 3'h0, 4'h0);
      chk({o_torque_limit_select_bit, o_speed_limit_select_bit}, {k == 3 || k == 4, k == 1});
    end
    for (int k = 0; k < 4; k++) begin
      frm(cbit(B_HOME_ARM, k[0]), 3'h0, k[1] ? NCY_HOMING : 4'h0);
      i_home_trigger = 1'h1;
      tick(4);
      chk({o_home_armed, o_home_detected}, {2{k[0] & k[1]}});
      i_home_trigger = 1'h0;
      tick(4);
    end
    for (int k = 0; k < 16; k++) begin
      e = k[2] & ~k[3];
      c = k[1] & ~k[3] & ~e;
      p = k[0] & ~k[3] & ~e & ~c;
      frm(cbit(B_EHALT, k[2]) | cbit(B_CHALT, k[1]) | cbit(B_PAUSE, k[0]), k[3] ? 3'h2 : CYC_PROFILE, 4'h0);
      chk({o_profile_position_mode, o_profile_stop_gen, o_profile_end, o_profile_decel, o_profile_hold}, {~k[3], e, e | c, c | p, p});
    end
    for (int k = 0; k < 16; k++) begin
      {i_out_one_assigned, i_out_two_assigned} = k[3:2];
      frm({14'h0000, k[1:0]}, 3'h0, 4'h0);
      chk({o_network_output_two, o_network_output_one}, {k[2] & k[1], k[3] & k[0]});
    end
  endtask : t_main

  task automatic t_hold_retract();
    i_ext_enable_assigned = 1'h0;
    frm(cbit(B_SERVO_ON, 1'h1), 3'h0, 4'h0);
    host.send(16'h0000, 3'h0, 4'h0, 1'h1, 1'h0);
    tick(3);
    chk({4'h0, o_servo_on}, 5'h01);
    host.send(16'h8000, 3'h0, 4'h0, 1'h0, 1'h1);
    tick(3);
    chk({4'h0, o_servo_on}, 5'h00);
    frm(cbit(B_SERVO_ON, 1'h1), 3'h0, 4'h0);
    i_retract_active_flag = 1'h1;
    tick(4);
    chk({o_retract_error_alarm_a, o_retract_error_alarm_b}, 5'h00);
    frm(16'h0000, 3'h0, 4'h0);
    chk({o_retract_error_alarm_a, o_retract_error_alarm_b}, 5'h03);
    i_retract_active_flag = 1'h0;
    frm(cbit(B_SERVO_ON, 1'h1), 3'h0, 4'h0);
    chk({o_retract_error_alarm_a, o_retract_error_alarm_b}, 5'h03);
    i_rst_n = 1'h0;
    tick(2);
    chk({o_retract_error_alarm_a, o_retract_error_alarm_b, o_servo_on}, 5'h00);
    i_rst_n = 1'h1;
  endtask : t_hold_retract

  initial begin
    i_rst_n = 1'h0;
    {i_ext_enable_assigned, i_external_servo_enable_input, i_retract_active_flag} = 3'h0;
    {i_rt_autotune_on, i_second_gain_en, i_net_gain_switch_en, i_home_trigger} = 4'h0;
    {i_out_one_assigned, i_out_two_assigned} = 2'h0;
    i_sensor_feedback_mode_param = 4'h0;
    i_torque_limit_selection_param = 4'h0;
    i_speed_limit_selection_param = 4'h0;
    tick(2);
    i_rst_n = 1'h1;
    chk({o_servo_on, o_profile_end, o_retract_error_alarm_a, o_network_output_one, o_home_armed}, 5'h00);
    t_main();
    t_hold_retract();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
